//--- sim/srap_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module srap_i2c_host (
	// pacing clock
	input  wire logic clk,
	// bus lines, sda is open drain with a pull-up
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// ====
	// one quarter of the 160 ns bus period per move, scl stands still between frames
	task automatic mv(input logic c, input logic d);
		scl = c;
		sda_low = d;
		repeat (2) @(negedge clk);
	endtask
	task automatic start;
		mv(scl, 1'b0);
		mv(1'b1, 1'b0);
		mv(1'b1, 1'b1);
		mv(1'b0, 1'b1);
	endtask
	task automatic stop;
		mv(1'b0, 1'b1);
		mv(1'b1, 1'b1);
		mv(1'b1, 1'b0);
	endtask
	task automatic bit_x(input logic b, output logic r);
		mv(1'b0, ~b);
		mv(1'b1, ~b);
		r = sda;
		mv(1'b1, ~b);
		mv(1'b0, ~b);
	endtask
	// a read byte is sent as all ones so the device alone drives the line
	task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r, output logic ack_n);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(~m_ack, ack_n);
	endtask
endmodule // srap_i2c_host
`default_nettype wire

//--- sim/srap_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module srap_top_checker (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       ext_reset_n,
	// serial pins
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       so_out,
	input wire logic       so_oe,
	// expander and interrupt pins
	input wire logic [7:0] expander_pin_out,
	input wire logic [7:0] expander_pin_oe,
	input wire logic [7:0] pullup_enable,
	input wire logic       int_out,
	input wire logic       int_oe
);
	default clocking cb @(posedge core_clk);
	endclocking
	// the reset pin clears registers asynchronously to the bus, so it masks the checks too
	default disable iff (rst || !ext_reset_n);
	// ====
	// a pull on sda must outlast the clock high phase, or the host samples a glitch
	sequence pull_start_s;
		$rose(sda_oe);
	endsequence
	sequence pull_held_s;
		sda_oe [*6];
	endsequence
	a_sda_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");
	a_ack_stands: assert property (pull_start_s |-> pull_held_s) else $error("sda pull too short");
	a_so_released: assert property (!so_oe && !so_out) else $error("spi output active");
	a_reset_pins_in: assert property ($fell(rst) |-> expander_pin_oe == 8'h00) else $error("pins driven");
	a_reset_regs_clear: assert property ($fell(rst) |-> expander_pin_out == 8'h00 && pullup_enable == 8'h00)
		else $error("register not cleared");
	a_int_idle_high: assert property ($fell(rst) |-> int_oe && int_out) else $error("int not idle");
	a_int_od_level: assert property (!int_oe |-> !int_out) else $error("int released high");
	// commits land at the end of a byte, which in I2C mode is always inside a clock low phase
	a_latch_scl_low: assert property ($changed(expander_pin_out) |-> !scl_in || !$past(scl_in))
		else $error("latch moved mid bit");
	a_dir_scl_low: assert property ($changed(expander_pin_oe) |-> !scl_in || !$past(scl_in))
		else $error("direction moved mid bit");
endmodule // srap_top_checker
`default_nettype wire

//--- sim/srap_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module srap_top_tb_top;
	localparam logic [3:0] FIX = 4'h4;
	logic        core_clk;
	logic        rst;
	logic        ext_n;
	logic [2:0]  hw;
	logic [7:0]  pins;
	logic [7:0]  v;
	logic [7:0]  w;
	logic [7:0]  lat;
	logic        nak;
	logic [31:0] seed;
	logic [7:0]  exp_q[$];
	logic [7:0]  seen_q[$];
	logic [7:0]  wq[$];
	int          failures;
	int          n_tests;
	event        rd_ev;
	wire         scl;
	wire         host_low;
	wire         sda_oe;
	wire         sda = !(host_low || sda_oe);
	wire [7:0]   pin_out;
	wire [7:0]   pin_oe;
	wire [7:0]   pull_en;
	wire         int_out;
	wire         int_oe;
	srap_top #(.I2C_FIXED_ADDR(FIX)) srap_top_inst (.core_clk(core_clk), .rst(rst), .ext_reset_n(ext_n),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .cs_n(1'b1), .so_out(), .so_oe(),
		.hw_addr_bit2(hw[2]), .hw_addr_bit1(hw[1]), .hw_addr_bit0(hw[0]), .expander_pin_in(pins),
		.expander_pin_out(pin_out), .expander_pin_oe(pin_oe), .pullup_enable(pull_en),
		.int_out(int_out), .int_oe(int_oe));
	srap_i2c_host srap_i2c_host_inst (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(host_low));
	// ====
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rnd(output logic [7:0] r);
		seed = lfsr(seed);
		r = seed[7:0];
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic look(input logic [7:0] seen, input logic [7:0] exp);
		exp_q.push_back(exp);
		seen_q.push_back(seen);
		->rd_ev;
	endtask
	task automatic ctl(input logic rw, input logic [2:0] a);
		logic [7:0] r;
		srap_i2c_host_inst.start();
		srap_i2c_host_inst.xfer({FIX, a, rw}, 1'b0, r, nak);
	endtask
	task automatic wr(input logic [7:0] a);
		logic [7:0] r;
		ctl(1'b0, hw);
		srap_i2c_host_inst.xfer(a, 1'b0, r, nak);
		foreach (wq[i]) begin
			srap_i2c_host_inst.xfer(wq[i], 1'b0, r, nak);
			look({7'h00, nak}, 8'h00);
		end
		wq.delete();
		srap_i2c_host_inst.stop();
	endtask
	// the last byte is refused by the host so the device lets go of sda
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] r;
		ctl(1'b0, hw);
		srap_i2c_host_inst.xfer(a, 1'b0, r, nak);
		ctl(1'b1, hw);
		for (int i = 0; i < n; i++) begin
			srap_i2c_host_inst.xfer(8'hFF, i < n - 1, r, nak);
			seen_q.push_back(r);
			->rd_ev;
		end
		srap_i2c_host_inst.stop();
	endtask
	// ====
	// clock, watchdog, result watcher
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		finish_test();
	end
	initial begin
		forever begin
			@(rd_ev);
			while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
		end
	end
	// ====
	// main sequence
	initial begin
		rst = 1'b1;
		ext_n = 1'b1;
		hw = 3'b101;
		seed = 32'h11B5;
		failures = 0;
		n_tests = 0;
		rnd(pins);
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		exp_q = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, pins, 8'h00, 8'hFF};
		rd(8'h00, 12);
		look(pin_oe, 8'h00);
		rnd(lat);
		wq = '{lat, 8'h0F};
		wr(8'h0A);
		look(pin_out, lat);
		look(pin_oe, 8'hF0);
		rnd(v);
		wq = '{8'hFF, 8'hFF, v};
		wr(8'h07);
		look(pin_out, v);
		exp_q = {exp_q, 8'h00, 8'h00, pins, v};
		rd(8'h07, 4);
		lat = v;
		wq = '{8'h20};
		wr(8'h05);
		rnd(v);
		rnd(w);
		wq = '{v, w};
		wr(8'h06);
		look(pull_en, w);
		exp_q = {exp_q, w, w};
		rd(8'h06, 2);
		wq = '{8'h00};
		wr(8'h05);
		rnd(v);
		wq = '{v};
		wr(8'h01);
		exp_q.push_back(pins ^ v);
		rd(8'h09, 1);
		wq = '{8'h00, 8'h01};
		wr(8'h01);
		pins[0] = ~pins[0];
		repeat (8) @(negedge core_clk);
		look({7'h00, int_out}, 8'h00);
		exp_q.push_back(pins);
		rd(8'h08, 1);
		look({7'h00, int_out}, 8'h01);
		wq = '{8'h04};
		wr(8'h05);
		look({6'h00, int_oe, int_out}, 8'h00);
		ctl(1'b0, ~hw);
		look({7'h00, nak}, 8'h01);
		srap_i2c_host_inst.xfer(8'h0A, 1'b0, v, nak);
		srap_i2c_host_inst.xfer(8'hA5, 1'b0, v, nak);
		look({7'h00, nak}, 8'h01);
		srap_i2c_host_inst.stop();
		look(pin_out, lat);
		hw = ~hw;
		ctl(1'b0, hw);
		look({7'h00, nak}, 8'h00);
		srap_i2c_host_inst.xfer(8'h0A, 1'b0, v, nak);
		for (int i = 0; i < 4; i++) srap_i2c_host_inst.bit_x(1'b0, nak);
		srap_i2c_host_inst.stop();
		look(pin_out, lat);
		// external reset pin in mid-run must restore the defaults
		ext_n = 1'b0;
		repeat (6) @(negedge core_clk);
		ext_n = 1'b1;
		repeat (4) @(negedge core_clk);
		look(pin_out, 8'h00);
		look(pin_oe, 8'h00);
		finish_test();
	end
endmodule // srap_top_tb_top
bind srap_top srap_top_checker srap_top_checker_inst (.core_clk(core_clk), .rst(rst),
	.ext_reset_n(ext_reset_n), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .so_out(so_out), .so_oe(so_oe), .expander_pin_out(expander_pin_out),
	.expander_pin_oe(expander_pin_oe), .pullup_enable(pullup_enable), .int_out(int_out), .int_oe(int_oe));
`default_nettype wire

//--- verilog/srap_map.vh
// Contract
// R1: eleven byte registers at 00h..0Ah; interrupt capture at 08h is read-only.
// R2: auto-increment disable at 0 advances pointer after every byte.
// R3: auto-increment disable at 1 holds pointer fixed for repeated access.
// R4: after reset auto-increment is enabled (sequential mode).
// R5: I2C write: control, register address, data; device acks each data byte.
// R6: write byte commits on completion; byte cut by STOP or START is discarded.
// R7: I2C write advances pointer after each acknowledge the device returns.
// R8: I2C read: address set by write, then START plus read control byte.
// R9: master keeps clocking for sequential access, ends with STOP or START.
// R10: pointer wraps to zero after highest register address on both variants.
// R11: SPI write: chip select low, write opcode, register address, data bytes.
// R12: SPI read: read opcode and address, device shifts out data bytes.
// R13: SPI sequential access continues while chip select low, ends when it rises.
// R14: respond only when control byte address bits equal the address pins.
// R15: reset loads every register default and initialises the state machine.
// R16: after reset all eight port pins are inputs.
// R17: interrupt on change from previous state or mismatch to default compare.
// R18: port value is latched into interrupt capture when interrupt occurs.
// R19: port register read is inverted per bit by input polarity.
// R20: interrupt pin drives active high, active low, or open drain.
// R21: every register is readable over the serial interface.
// R22: port read gives pins, port write sets latch, latch read gives latch.
// R23: direction bit 1 makes pin input with driver off, 0 makes output.
// R24: on I2C address mismatch no acknowledge, ignore traffic until next START.
// R25: SPI data output released when chip select high or not shifting read data.
`ifndef SRAP_MAP_VH
`define SRAP_MAP_VH

// ==========================================
// register offsets
`define SRAP_REG_IO_DIRECTION    8'h00
`define SRAP_REG_INPUT_POLARITY  8'h01
`define SRAP_REG_CHANGE_INT_EN   8'h02
`define SRAP_REG_DEFAULT_COMPARE 8'h03
`define SRAP_REG_INT_COMPARE_SEL 8'h04
`define SRAP_REG_DEVICE_CONFIG   8'h05
`define SRAP_REG_PULLUP_ENABLE   8'h06
`define SRAP_REG_INTERRUPT_FLAG  8'h07
`define SRAP_REG_INT_CAPTURE     8'h08
`define SRAP_REG_PORT_VALUE      8'h09
`define SRAP_REG_OUTPUT_LATCH    8'h0A
`define SRAP_REG_LAST            8'h0A

// ==========================================
// device_config fields
`define SRAP_CFG_AUTO_INC_DIS 5
`define SRAP_CFG_SLEW_DIS     4
`define SRAP_CFG_HW_ADDR_EN   3
`define SRAP_CFG_OPEN_DRAIN   2
`define SRAP_CFG_INT_POLARITY 1
`define SRAP_CFG_WR_MASK      8'h3E

// ==========================================
// reset values
`define SRAP_RST_IO_DIRECTION 8'hFF
`define SRAP_RST_ZERO         8'h00

// ==========================================
// serial framing
`define SRAP_BITS_PER_BYTE 4'h8
`endif

//--- verilog/srap_top.v
`timescale 1ns/1ps
`default_nettype none
`include "srap_map.vh"

module srap_top #(
	parameter        SPI_MODE       = 0,
	parameter [3:0]  I2C_FIXED_ADDR = 4'h4,
	parameter [4:0]  SPI_FIXED_ADDR = 5'h08
) (
	// clock and reset
	input  wire       core_clk,
	input  wire       rst,
	input  wire       ext_reset_n,
	// serial pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire       cs_n,
	output wire       so_out,
	output wire       so_oe,
	// hardware address pins
	input  wire       hw_addr_bit2,
	input  wire       hw_addr_bit1,
	input  wire       hw_addr_bit0,
	// expander port
	input  wire [7:0] expander_pin_in,
	output wire [7:0] expander_pin_out,
	output wire [7:0] expander_pin_oe,
	output wire [7:0] pullup_enable,
	// interrupt pin
	output wire       int_out,
	output wire       int_oe
);

	// ==========================================
	// state encoding
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_RX   = 6'h02;
	localparam [5:0] ST_ACK  = 6'h04;
	localparam [5:0] ST_TX   = 6'h08;
	localparam [5:0] ST_RACK = 6'h10;
	localparam [5:0] ST_TXLD = 6'h20;

	// ==========================================
	// synchronisers
	// every pin is asynchronous to core_clk; two flops before any logic looks at it
	wire [14:0] raw_in = {expander_pin_in, hw_addr_bit2, hw_addr_bit1, hw_addr_bit0,
		ext_reset_n, cs_n, sda_in, scl_in};
	reg  [14:0] meta_ff;
	reg  [14:0] sync_ff;
	reg  [2:0]  hist_ff;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_ff <= 15'h001F;
			sync_ff <= 15'h001F;
		end else begin
			meta_ff <= raw_in;
			sync_ff <= meta_ff;
		end
	end

	wire       scl_s  = sync_ff[0];
	wire       sda_s  = sync_ff[1];
	wire       cs_s   = sync_ff[2];
	wire       rstn_s = sync_ff[3];
	wire [2:0] hwa_s  = sync_ff[6:4];
	wire [7:0] pin_s  = sync_ff[14:7];

	// external reset pin joins the async reset; driven from a flop so it cannot glitch
	wire int_rst = rst | ~rstn_s;

	always @(posedge core_clk or posedge int_rst) begin
		if (int_rst)
			hist_ff <= 3'h7;
		else
			hist_ff <= {cs_s, sda_s, scl_s};
	end

	// ==========================================
	// serial events
	wire sc_rise = scl_s & ~hist_ff[0];
	wire sc_fall = ~scl_s & hist_ff[0];
	wire i2c_start = scl_s & hist_ff[0] & hist_ff[1] & ~sda_s;
	wire i2c_stop  = scl_s & hist_ff[0] & ~hist_ff[1] & sda_s;
	wire spi_sel   = ~cs_s;
	wire frm_start = SPI_MODE ? (hist_ff[2] & ~cs_s) : i2c_start;
	wire frm_stop  = SPI_MODE ? (~hist_ff[2] & cs_s) : i2c_stop;
	wire bit_rise  = SPI_MODE ? (sc_rise & spi_sel) : sc_rise;
	wire bit_fall  = SPI_MODE ? (sc_fall & spi_sel) : sc_fall;

	// ==========================================
	// register file storage
	reg [7:0] io_direction_ff;
	reg [7:0] input_polarity_ff;
	reg [7:0] change_interrupt_enable_ff;
	reg [7:0] default_compare_ff;
	reg [7:0] interrupt_compare_select_ff;
	reg [7:0] device_config_ff;
	reg [7:0] pullup_enable_ff;
	reg [7:0] interrupt_flag_ff;
	reg [7:0] interrupt_capture_ff;
	reg [7:0] output_latch_ff;
	reg [7:0] prev_pin_ff;

	wire [7:0] port_read = pin_s ^ input_polarity_ff; // R19 R22
	wire       seq_hold  = device_config_ff[`SRAP_CFG_AUTO_INC_DIS];

	// register read decode, used at every load of the transmit shifter
	function [7:0] read_reg;
		input [7:0] a;
		begin
			case (a) // R21
				`SRAP_REG_IO_DIRECTION:    read_reg = io_direction_ff;
				`SRAP_REG_INPUT_POLARITY:  read_reg = input_polarity_ff;
				`SRAP_REG_CHANGE_INT_EN:   read_reg = change_interrupt_enable_ff;
				`SRAP_REG_DEFAULT_COMPARE: read_reg = default_compare_ff;
				`SRAP_REG_INT_COMPARE_SEL: read_reg = interrupt_compare_select_ff;
				`SRAP_REG_DEVICE_CONFIG:   read_reg = device_config_ff;
				`SRAP_REG_PULLUP_ENABLE:   read_reg = pullup_enable_ff;
				`SRAP_REG_INTERRUPT_FLAG:  read_reg = interrupt_flag_ff;
				`SRAP_REG_INT_CAPTURE:     read_reg = interrupt_capture_ff;
				`SRAP_REG_PORT_VALUE:      read_reg = port_read; // R22
				`SRAP_REG_OUTPUT_LATCH:    read_reg = output_latch_ff; // R22
				default:                   read_reg = 8'h00;
			endcase
		end
	endfunction

	// pointer step: hold in byte mode, wrap after the last register
	function [7:0] ptr_step;
		input [7:0] p;
		input       hold;
		begin
			if (hold)
				ptr_step = p; // R3
			else if (p >= `SRAP_REG_LAST)
				ptr_step = 8'h00; // R10
			else
				ptr_step = p + 8'h01; // R2
		end
	endfunction

	// ==========================================
	// serial engine
	reg [5:0] state_ff;
	reg [3:0] bitcnt_ff;
	reg [7:0] shreg_ff;
	reg [7:0] ptr_ff;
	reg [1:0] byte_idx_ff;
	reg       rw_ff;
	reg       adv_pend_ff;
	reg       wr_req_ff;
	reg [7:0] wr_addr_ff;
	reg [7:0] wr_data_ff;
	reg       rd_req_ff;
	reg [7:0] rd_addr_ff;

	wire       din      = sda_s;
	wire [7:0] rx_byte  = {shreg_ff[6:0], din};
	wire [7:0] ptr_nxt  = ptr_step(ptr_ff, seq_hold);
	wire       i2c_hit  = (shreg_ff[7:1] == {I2C_FIXED_ADDR, hwa_s}); // R14
	wire       spi_hit  = (rx_byte[7:1] == {SPI_FIXED_ADDR, hwa_s[1:0]}); // R14
	wire       byte_end = (bitcnt_ff == `SRAP_BITS_PER_BYTE);
	wire       last_bit = (bitcnt_ff == 4'h7);

	always @(posedge core_clk or posedge int_rst) begin
		if (int_rst) begin // R15
			state_ff    <= ST_IDLE;
			bitcnt_ff   <= 4'h0;
			shreg_ff    <= 8'h00;
			ptr_ff      <= 8'h00;
			byte_idx_ff <= 2'h0;
			rw_ff       <= 1'b0;
			adv_pend_ff <= 1'b0;
			wr_req_ff   <= 1'b0;
			wr_addr_ff  <= 8'h00;
			wr_data_ff  <= 8'h00;
			rd_req_ff   <= 1'b0;
			rd_addr_ff  <= 8'h00;
		end else begin
			wr_req_ff <= 1'b0;
			rd_req_ff <= 1'b0;
			if (frm_stop) begin
				// a partial byte simply never reaches the commit point
				state_ff <= ST_IDLE; // R6 R13
			end else if (frm_start) begin
				state_ff    <= ST_RX; // R24
				bitcnt_ff   <= 4'h0;
				byte_idx_ff <= 2'h0;
				adv_pend_ff <= 1'b0;
			end else begin
				case (state_ff)
				ST_RX: begin
					if (bit_rise) begin
						shreg_ff  <= rx_byte;
						bitcnt_ff <= bitcnt_ff + 4'h1;
						if (SPI_MODE && last_bit) begin
							bitcnt_ff <= 4'h0;
							if (byte_idx_ff != 2'h2)
								byte_idx_ff <= byte_idx_ff + 2'h1;
							if (byte_idx_ff == 2'h0) begin
								rw_ff <= rx_byte[0];
								if (!spi_hit)
									state_ff <= ST_IDLE; // R14
							end else if (byte_idx_ff == 2'h1) begin
								ptr_ff <= rx_byte; // R11 R12
								if (rw_ff) begin
									shreg_ff   <= read_reg(rx_byte); // R12
									rd_req_ff  <= 1'b1;
									rd_addr_ff <= rx_byte;
									state_ff   <= ST_TX;
								end
							end else begin
								wr_req_ff  <= 1'b1; // R6
								wr_addr_ff <= ptr_ff;
								wr_data_ff <= rx_byte;
								ptr_ff     <= ptr_nxt; // R2 R13
							end
						end
					end else if (!SPI_MODE && bit_fall && byte_end) begin
						bitcnt_ff <= 4'h0;
						state_ff  <= ST_ACK; // R5
						if (byte_idx_ff != 2'h2)
							byte_idx_ff <= byte_idx_ff + 2'h1;
						if (byte_idx_ff == 2'h0) begin
							rw_ff <= shreg_ff[0];
							if (!i2c_hit)
								state_ff <= ST_IDLE; // R24
							else if (shreg_ff[0]) begin
								shreg_ff   <= read_reg(ptr_ff); // R8
								rd_req_ff  <= 1'b1;
								rd_addr_ff <= ptr_ff;
							end
						end else if (byte_idx_ff == 2'h1) begin
							ptr_ff <= shreg_ff;
						end else begin
							wr_req_ff   <= 1'b1; // R6
							wr_addr_ff  <= ptr_ff;
							wr_data_ff  <= shreg_ff;
							adv_pend_ff <= 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (bit_fall) begin
						adv_pend_ff <= 1'b0;
						if (adv_pend_ff)
							ptr_ff <= ptr_nxt; // R7
						state_ff <= rw_ff ? ST_TX : ST_RX;
					end
				end
				ST_TX: begin
					if (bit_rise) begin
						bitcnt_ff <= bitcnt_ff + 4'h1;
						if (SPI_MODE && last_bit) begin
							// reload at once so the next msb is ready before the next fall
							bitcnt_ff  <= 4'h0;
							ptr_ff     <= ptr_nxt; // R2 R3 R13
							shreg_ff   <= read_reg(ptr_nxt);
							rd_req_ff  <= 1'b1;
							rd_addr_ff <= ptr_nxt;
						end
					end else if (bit_fall) begin
						if (!SPI_MODE && byte_end) begin
							bitcnt_ff <= 4'h0;
							state_ff  <= ST_RACK;
						end else if (bitcnt_ff != 4'h0) begin
							shreg_ff <= {shreg_ff[6:0], 1'b0};
						end
					end
				end
				ST_RACK: begin
					if (bit_rise) begin
						ptr_ff   <= ptr_nxt; // R2 R9 R10
						state_ff <= din ? ST_IDLE : ST_TXLD;
					end
				end
				ST_TXLD: begin
					if (bit_fall) begin
						shreg_ff   <= read_reg(ptr_ff); // R9
						rd_req_ff  <= 1'b1;
						rd_addr_ff <= ptr_ff;
						state_ff   <= ST_TX;
					end
				end
				ST_IDLE: begin
					bitcnt_ff <= 4'h0;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ==========================================
	// register file and interrupt logic
	wire [7:0] int_cond = change_interrupt_enable_ff & io_direction_ff &
		((interrupt_compare_select_ff & (pin_s ^ default_compare_ff)) |
		(~interrupt_compare_select_ff & (pin_s ^ prev_pin_ff))); // R17
	// reading capture or port releases the flags; a fresh event in that cycle still wins
	wire       rd_clear = rd_req_ff && ((rd_addr_ff == `SRAP_REG_INT_CAPTURE) ||
		(rd_addr_ff == `SRAP_REG_PORT_VALUE));
	wire [7:0] flag_kept = rd_clear ? 8'h00 : interrupt_flag_ff;

	always @(posedge core_clk or posedge int_rst) begin
		if (int_rst) begin // R15 R4 R16
			io_direction_ff             <= `SRAP_RST_IO_DIRECTION;
			input_polarity_ff           <= `SRAP_RST_ZERO;
			change_interrupt_enable_ff  <= `SRAP_RST_ZERO;
			default_compare_ff          <= `SRAP_RST_ZERO;
			interrupt_compare_select_ff <= `SRAP_RST_ZERO;
			device_config_ff            <= `SRAP_RST_ZERO;
			pullup_enable_ff            <= `SRAP_RST_ZERO;
			interrupt_flag_ff           <= `SRAP_RST_ZERO;
			interrupt_capture_ff        <= `SRAP_RST_ZERO;
			output_latch_ff             <= `SRAP_RST_ZERO;
			prev_pin_ff                 <= `SRAP_RST_ZERO;
		end else begin
			prev_pin_ff       <= pin_s;
			interrupt_flag_ff <= flag_kept | int_cond;
			if ((|int_cond) && (flag_kept == 8'h00))
				interrupt_capture_ff <= port_read; // R18
			if (wr_req_ff) begin
				case (wr_addr_ff) // R1
					`SRAP_REG_IO_DIRECTION:    io_direction_ff <= wr_data_ff;
					`SRAP_REG_INPUT_POLARITY:  input_polarity_ff <= wr_data_ff;
					`SRAP_REG_CHANGE_INT_EN:   change_interrupt_enable_ff <= wr_data_ff;
					`SRAP_REG_DEFAULT_COMPARE: default_compare_ff <= wr_data_ff;
					`SRAP_REG_INT_COMPARE_SEL: interrupt_compare_select_ff <= wr_data_ff;
					`SRAP_REG_DEVICE_CONFIG:   device_config_ff <= wr_data_ff & `SRAP_CFG_WR_MASK;
					`SRAP_REG_PULLUP_ENABLE:   pullup_enable_ff <= wr_data_ff;
					`SRAP_REG_PORT_VALUE:      output_latch_ff <= wr_data_ff; // R22
					`SRAP_REG_OUTPUT_LATCH:    output_latch_ff <= wr_data_ff; // R22
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================
	// pin drivers
	wire int_active = |interrupt_flag_ff;
	wire int_odr    = device_config_ff[`SRAP_CFG_OPEN_DRAIN];
	wire int_hi     = device_config_ff[`SRAP_CFG_INT_POLARITY];

	assign int_out = int_odr ? 1'b0 : ~(int_active ^ int_hi); // R20
	assign int_oe  = int_odr ? int_active : 1'b1; // R20

	assign expander_pin_out = output_latch_ff;
	assign expander_pin_oe  = ~io_direction_ff; // R23 R16
	assign pullup_enable    = pullup_enable_ff;

	// open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe  = !SPI_MODE && ((state_ff == ST_ACK) ||
		((state_ff == ST_TX) && !shreg_ff[7])); // R5 R8
	assign so_out  = SPI_MODE ? shreg_ff[7] : 1'b0;
	assign so_oe   = SPI_MODE && spi_sel && (state_ff == ST_TX); // R25

endmodule // srap_top
`default_nettype wire
